// >>> hdl/scps_top.sv
// system clock source selection, start-up timing, trim and prescaler
// Function
// - fuse codes 0110 or 0111 select the watch crystal oscillator
// - watch crystal reset delay is 14 cycles, plus 4.1 or 65 ms with start-up fuses 01 or 10
// - watch crystal wake-up takes 1K or 32K cycles by select code
// - fuse code 0010 selects the internal 8 MHz RC oscillator
// - every reset copies the factory trim byte into the trim register
// - RC wake-up takes 6 cycles; reset delay as for the crystal
// - timer oscillator usable only while the RC oscillator is selected
// - watchdog oscillator times the reset time-out for every source
// - trim zero is slowest, larger values faster, all ones fastest
// - fuse code 0000 takes an external clock on the crystal input
// - external clock wake-up takes 6 cycles; reset delay as above
// - programmed output fuse puts the system clock on the output pin
// - clock output pin carries the divided system clock
// - external clock select bit replaces the timer crystal input
// - prescaler divides I/O, ADC, CPU and flash clocks
// - prescaler changes are glitch-free with no faster intermediate
// - new division takes effect at the end of the current old period
// - division value accepted only within four cycles of the unlock
// - change-enable clears after four cycles or on the value write
// - division codes 0 to 8 give 1 to 256; 9 to 15 reserved
// - reset loads division code 0000, or 0011 with divide-by-8 fuse
`timescale 1ns/1ps
module scps_top #(
	parameter int WDT_LONG_CYCLES = scps_pkg::WDT_LONG,
	parameter int WAKE_LF_SLOW_CYCLES = scps_pkg::WAKE_LF_SLOW
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// fuses and factory data
	input wire logic [3:0] i_clock_source_select_fuses,
	input wire logic [1:0] i_startup_time_fuses,
	input wire logic i_clock_output_fuse,
	input wire logic i_initial_divide_by_eight_fuse,
	input wire logic [7:0] i_factory_trim,
	// watchdog oscillator pin and wake request
	input wire logic i_wdt_osc,
	input wire logic i_wake_req,
	// normal port function of the clock output pin
	input wire logic i_port_out,
	input wire logic i_port_oe,
	// clock outputs
	output logic o_sys_clk,
	output logic o_sys_clk_en,
	output logic o_clock_output_pin,
	output logic o_clock_output_pin_oe,
	// oscillator controls
	output logic [1:0] o_source,
	output logic [6:0] o_rc_trim_value,
	output logic o_timer_osc_enable,
	output logic o_timer_external_clock_select,
	output logic o_core_run
);
	typedef enum logic [2:0] {
		SEQ_LOAD, SEQ_CK14, SEQ_WDT, SEQ_RUN, SEQ_WAKE, SEQ_HALT
	} scps_seq_t;

	localparam int CW = scps_pkg::CNT_W;

	scps_div_if div_link ();

	scps_divider u_div (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.div(div_link.div)
	);

	// fuse image, taken in the load cycle after reset release
	logic [3:0] clock_source_select_fuses, next_clock_source_select_fuses;
	logic [1:0] startup_time_fuses, next_sut;
	logic clock_output_fuse, next_clock_output_fuse;
	logic fuse_valid, next_fuse_valid;
	scps_pkg::scps_src_t src;

	// sequencer
	scps_seq_t seq, next_seq;
	logic [CW-1:0] seq_cnt, next_seq_cnt;
	logic [CW-1:0] wdt_lim, wake_lim;

	// watchdog oscillator synchroniser and edge detect
	logic wdt_s1, wdt_s2, wdt_s3, wdt_edge;

	// registers
	logic [3:0] ps, next_ps;
	logic pce, next_pce;
	logic [1:0] pce_cnt, next_pce_cnt;
	logic [7:0] trim, next_trim;
	logic [1:0] timer, next_timer;
	logic [31:0] rdata, next_rdata;

	// bus decode
	logic wr, setup, hit;
	logic [7:0] wd;

	assign setup = i_psel && !i_penable;
	assign wr = i_psel && i_penable && i_pwrite;
	assign wd = i_pwdata[7:0];
	assign hit = (i_paddr == scps_pkg::ADDR_PRESCALE) ||
		(i_paddr == scps_pkg::ADDR_TRIM) ||
		(i_paddr == scps_pkg::ADDR_TIMER) ||
		(i_paddr == scps_pkg::ADDR_STATUS);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_prdata = rdata;

	always_comb begin
		next_clock_source_select_fuses = clock_source_select_fuses;
		next_sut = startup_time_fuses;
		next_clock_output_fuse = clock_output_fuse;
		next_fuse_valid = 1'b1;
		if (seq == SEQ_LOAD) begin
			next_clock_source_select_fuses = i_clock_source_select_fuses;
			next_sut = i_startup_time_fuses;
			next_clock_output_fuse = i_clock_output_fuse;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			clock_source_select_fuses <= scps_pkg::CLOCK_SOURCE_SELECT_FUSES_RC;
			startup_time_fuses <= 2'h0;
			clock_output_fuse <= 1'b1;
			fuse_valid <= 1'b0;
		end else begin
			clock_source_select_fuses <= next_clock_source_select_fuses;
			startup_time_fuses <= next_sut;
			clock_output_fuse <= next_clock_output_fuse;
			fuse_valid <= next_fuse_valid;
		end
	end

	assign src = fuse_valid ? scps_pkg::scps_decode(clock_source_select_fuses)
		: scps_pkg::SRC_NONE;
	assign o_source = src;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wdt_s1 <= 1'b0;
			wdt_s2 <= 1'b0;
			wdt_s3 <= 1'b0;
		end else begin
			wdt_s1 <= i_wdt_osc;
			wdt_s2 <= wdt_s1;
			wdt_s3 <= wdt_s2;
		end
	end
	assign wdt_edge = wdt_s2 && !wdt_s3;

	always_comb begin
		wdt_lim = (startup_time_fuses == scps_pkg::SUT_LONG) ? CW'(WDT_LONG_CYCLES - 1)
			: CW'(scps_pkg::WDT_SHORT - 1);
		if (src != scps_pkg::SRC_LF_XTAL)
			wake_lim = CW'(scps_pkg::WAKE_RC_EXT - 1);
		else if (clock_source_select_fuses == scps_pkg::CLOCK_SOURCE_SELECT_FUSES_LF_SLOW)
			wake_lim = CW'(WAKE_LF_SLOW_CYCLES - 1);
		else
			wake_lim = CW'(scps_pkg::WAKE_LF_FAST - 1);
	end

	always_comb begin
		next_seq = seq;
		next_seq_cnt = seq_cnt + CW'(1);
		case (seq)
			SEQ_LOAD: begin
				next_seq_cnt = '0;
				next_seq = (scps_pkg::scps_decode(i_clock_source_select_fuses)
					== scps_pkg::SRC_NONE) ? SEQ_HALT : SEQ_CK14;
			end
			SEQ_CK14: begin
				if (seq_cnt == CW'(scps_pkg::RESET_CK - 1)) begin
					next_seq_cnt = '0;
					next_seq = (startup_time_fuses == scps_pkg::SUT_SHORT ||
						startup_time_fuses == scps_pkg::SUT_LONG) ? SEQ_WDT : SEQ_RUN;
				end
			end
			SEQ_WDT: begin
				next_seq_cnt = seq_cnt + CW'(wdt_edge);
				if (wdt_edge && seq_cnt == wdt_lim)
					next_seq = SEQ_RUN;
			end
			SEQ_RUN: begin
				next_seq_cnt = '0;
				if (i_wake_req)
					next_seq = SEQ_WAKE;
			end
			SEQ_WAKE: begin
				if (seq_cnt == wake_lim) begin
					next_seq_cnt = '0;
					next_seq = SEQ_RUN;
				end
			end
			SEQ_HALT: next_seq_cnt = '0;
			default: next_seq = SEQ_HALT;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			seq <= SEQ_LOAD;
			seq_cnt <= '0;
		end else begin
			seq <= next_seq;
			seq_cnt <= next_seq_cnt;
		end
	end
	assign o_core_run = (seq == SEQ_RUN);

	// register writes and the prescale unlock window
	always_comb begin
		next_ps = ps;
		next_pce = pce;
		next_pce_cnt = pce_cnt;
		next_trim = trim;
		next_timer = timer;
		if (pce) begin
			next_pce_cnt = pce_cnt + 2'h1;
			if (pce_cnt == 2'(scps_pkg::PCE_WINDOW - 1))
				next_pce = 1'b0;
		end
		if (wr && i_paddr == scps_pkg::ADDR_PRESCALE) begin
			if (pce && !wd[scps_pkg::PCE_BIT]) begin
				next_ps = wd[3:0];
				next_pce = 1'b0;
			end
			// set only with other bits zero
			if (!pce && wd == scps_pkg::PCE_UNLOCK) begin
				next_pce = 1'b1;
				next_pce_cnt = 2'h0;
			end
		end
		if (wr && i_paddr == scps_pkg::ADDR_TRIM)
			next_trim = wd;
		if (wr && i_paddr == scps_pkg::ADDR_TIMER)
			next_timer = wd[1:0];
		if (seq == SEQ_LOAD) begin
			next_trim = i_factory_trim;
			next_ps = (i_initial_divide_by_eight_fuse ==
				scps_pkg::FUSE_PROGRAMMED) ? scps_pkg::PS_RESET_DIV8
				: scps_pkg::PS_RESET_DIV1;
			next_pce = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ps <= scps_pkg::PS_RESET_DIV1;
			pce <= 1'b0;
			pce_cnt <= 2'h0;
			trim <= scps_pkg::TRIM_RESET;
			timer <= 2'h0;
		end else begin
			ps <= next_ps;
			pce <= next_pce;
			pce_cnt <= next_pce_cnt;
			trim <= next_trim;
			timer <= next_timer;
		end
	end

	// read data is captured in the setup phase
	always_comb begin
		next_rdata = rdata;
		if (setup) begin
			case (i_paddr)
				scps_pkg::ADDR_PRESCALE:
					next_rdata = {24'h000000, pce, 3'h0, ps};
				scps_pkg::ADDR_TRIM: next_rdata = {24'h000000, trim};
				scps_pkg::ADDR_TIMER: next_rdata = {30'h00000000, timer};
				scps_pkg::ADDR_STATUS:
					next_rdata = {24'h000000, pce, o_core_run, src, clock_source_select_fuses};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			rdata <= 32'h00000000;
		else
			rdata <= next_rdata;
	end

	assign o_rc_trim_value = trim[6:0];

	assign o_timer_osc_enable = timer[scps_pkg::TMR_OSC_EN_BIT] &&
		(src == scps_pkg::SRC_RC);
	assign o_timer_external_clock_select = o_timer_osc_enable &&
		timer[scps_pkg::TMR_TIMER_EXTERNAL_CLOCK_SELECT_BIT];

	assign div_link.sel = ps;
	assign o_sys_clk_en = div_link.tick;
	assign o_sys_clk = div_link.clk_half;

	logic clock_output_fuse_on;
	assign clock_output_fuse_on = (fuse_valid ? clock_output_fuse : i_clock_output_fuse) ==
		scps_pkg::FUSE_PROGRAMMED;
	assign o_clock_output_pin = clock_output_fuse_on ? div_link.clk_half : i_port_out;
	assign o_clock_output_pin_oe = clock_output_fuse_on ? 1'b1 : i_port_oe;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_wake6;
		(seq == SEQ_WAKE) [*6] ##1 (seq == SEQ_RUN);
	endsequence

	property p_lf_select;
		fuse_valid && (clock_source_select_fuses == scps_pkg::CLOCK_SOURCE_SELECT_FUSES_LF_FAST ||
			clock_source_select_fuses == scps_pkg::CLOCK_SOURCE_SELECT_FUSES_LF_SLOW) |-> src == scps_pkg::SRC_LF_XTAL;
	endproperty
	a_lf_select: assert property (p_lf_select)
		else $error("watch crystal code did not select crystal");

	property p_rc_select;
		fuse_valid && clock_source_select_fuses == scps_pkg::CLOCK_SOURCE_SELECT_FUSES_RC |->
			src == scps_pkg::SRC_RC;
	endproperty
	a_rc_select: assert property (p_rc_select)
		else $error("rc code did not select rc oscillator");

	property p_ext_select;
		fuse_valid && clock_source_select_fuses == scps_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT |->
			src == scps_pkg::SRC_EXT;
	endproperty
	a_ext_select: assert property (p_ext_select)
		else $error("external code did not select external clock");

	property p_ck14;
		(seq != SEQ_CK14) ##1 (seq == SEQ_CK14) |->
			##13 (seq == SEQ_CK14) ##1 (seq != SEQ_CK14);
	endproperty
	a_ck14: assert property (p_ck14)
		else $error("reset delay not 14 cycles");

	property p_wake_fast;
		seq == SEQ_RUN && i_wake_req && src != scps_pkg::SRC_LF_XTAL
			|=> s_wake6;
	endproperty
	a_wake_fast: assert property (p_wake_fast)
		else $error("wake-up not 6 cycles");

	property p_trim_load;
		!i_reset && seq == SEQ_LOAD |=> trim == $past(i_factory_trim);
	endproperty
	a_trim_load: assert property (p_trim_load)
		else $error("factory trim not loaded");

	property p_timer_osc;
		o_timer_osc_enable |-> src == scps_pkg::SRC_RC;
	endproperty
	a_timer_osc: assert property (p_timer_osc)
		else $error("timer oscillator on without rc source");

	property p_pce_expire;
		$rose(pce) |-> ##[1:4] !pce;
	endproperty
	a_pce_expire: assert property (p_pce_expire)
		else $error("change enable outlived four cycles");

	property p_ps_accept;
		$changed(ps) && $past(seq) != SEQ_LOAD |-> $past(pce);
	endproperty
	a_ps_accept: assert property (p_ps_accept)
		else $error("division changed outside the window");

	property p_clkout;
		fuse_valid && clock_output_fuse == scps_pkg::FUSE_PROGRAMMED |->
			o_clock_output_pin_oe && o_clock_output_pin == o_sys_clk;
	endproperty
	a_clkout: assert property (p_clkout)
		else $error("clock output pin not driven by system clock");
endmodule : scps_top

// >>> hdl/scps_pkg.sv
// shared constants, types and helpers of the system clock block
package scps_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] ADDR_PRESCALE = 8'h00;
	localparam logic [7:0] ADDR_TRIM = 8'h04;
	localparam logic [7:0] ADDR_TIMER = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	// prescale register fields
	localparam int PCE_BIT = 7;
	localparam logic [7:0] PCE_UNLOCK = 8'h80;
	localparam logic [3:0] PS_RESET_DIV1 = 4'h0;
	localparam logic [3:0] PS_RESET_DIV8 = 4'h3;
	localparam logic [3:0] PS_MAX = 4'h8;
	localparam int PCE_WINDOW = 4;
	// timer control register fields
	localparam int TMR_OSC_EN_BIT = 0;
	localparam int TMR_TIMER_EXTERNAL_CLOCK_SELECT_BIT = 1;
	// status register fields
	localparam int ST_SRC_LSB = 4;
	localparam int ST_RUN_BIT = 6;
	localparam int ST_PCE_BIT = 7;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	// source select codes; fuse bit 0 means programmed
	localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT = 4'h0;
	localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_RC = 4'h2;
	localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LF_FAST = 4'h6;
	localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_LF_SLOW = 4'h7;
	localparam logic [1:0] SUT_SHORT = 2'h1;
	localparam logic [1:0] SUT_LONG = 2'h2;
	localparam logic FUSE_PROGRAMMED = 1'b0;
	// start-up counts; WDT_SHORT and WDT_LONG in watchdog oscillator cycles, the rest in clock cycles
	localparam int RESET_CK = 14;
	localparam int WDT_SHORT = 4096;
	localparam int WDT_LONG = 65536;
	localparam int WAKE_RC_EXT = 6;
	localparam int WAKE_LF_FAST = 1024;
	localparam int WAKE_LF_SLOW = 32768;
	localparam int CNT_W = 17;

	typedef enum logic [1:0] {SRC_NONE, SRC_LF_XTAL, SRC_RC, SRC_EXT}
		scps_src_t;

	// division factor of a select code; reserved codes act as the largest
	function automatic logic [8:0] scps_factor(input logic [3:0] code);
		logic [3:0] c;
		c = (code > PS_MAX) ? PS_MAX : code;
		return 9'h001 << c;
	endfunction : scps_factor

	function automatic scps_src_t scps_decode(input logic [3:0] clock_source_select_fuses);
		case (clock_source_select_fuses)
			CLOCK_SOURCE_SELECT_FUSES_LF_FAST, CLOCK_SOURCE_SELECT_FUSES_LF_SLOW: return SRC_LF_XTAL;
			CLOCK_SOURCE_SELECT_FUSES_RC: return SRC_RC;
			CLOCK_SOURCE_SELECT_FUSES_EXT: return SRC_EXT;
			default: return SRC_NONE;
		endcase
	endfunction : scps_decode
endpackage : scps_pkg

// >>> hdl/scps_div_if.sv
// link between the clock control and the prescaler divider
`timescale 1ns/1ps
interface scps_div_if;
	logic [3:0] sel;
	logic tick;
	logic clk_half;
	modport ctrl(output sel, input tick, input clk_half);
	modport div(input sel, output tick, output clk_half);
endinterface : scps_div_if

// >>> hdl/scps_divider.sv
// glitch-free system clock prescaler counter
`timescale 1ns/1ps
module scps_divider (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// control side
	scps_div_if.div div
);
	logic [7:0] cnt, next_cnt;
	logic [3:0] cur, next_cur;
	logic half, next_half;
	logic wrap;
	logic [8:0] next_fac;

	always_comb begin
		wrap = (cnt == 8'(scps_pkg::scps_factor(cur) - 9'h001));
		next_cnt = wrap ? 8'h00 : cnt + 8'h01;
		next_cur = wrap ? div.sel : cur;
		next_fac = scps_pkg::scps_factor(next_cur);
		next_half = ({1'b0, next_cnt} < (next_fac >> 1));
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt <= 8'h00;
			cur <= 4'h0;
			half <= 1'b0;
		end else begin
			cnt <= next_cnt;
			cur <= next_cur;
			half <= next_half;
		end
	end

	assign div.tick = wrap;
	assign div.clk_half = (cur == 4'h0) ? i_clk : half;
endmodule : scps_divider

// >>> bench/scps_osc_model.sv
// watchdog oscillator model driving the start-up timer pin
`timescale 1ns/1ps
module scps_osc_model #(
	parameter int HALF_NS = 20
) (
	// speed control
	input wire logic i_slow,
	// oscillator output
	output logic o_wdt_osc
);
	initial begin
		o_wdt_osc = 1'b0;
		forever begin
			#(i_slow ? 2 * HALF_NS : HALF_NS);
			o_wdt_osc = ~o_wdt_osc;
		end
	end
endmodule : scps_osc_model

// >>> bench/scps_top_tb.sv
// self-checking bench of the system clock block
`timescale 1ns/1ps
module scps_top_tb;
	localparam int WDT_P = 5;
	localparam int LIMIT = 60000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] clock_source_select_fuses = 4'h2;
	logic [1:0] startup_time_fuses = 2'h0;
	logic clock_output_fuse = 1'b0;
	logic div8 = 1'b0;
	logic wake = 1'b0;
	logic port_out = 1'b1;
	logic port_oe = 1'b0;
	logic slow = 1'b0;
	logic wdt;
	logic sys_clk;
	logic sys_en;
	logic pin;
	logic pin_oe;
	logic [1:0] source;
	logic [6:0] rc_trim;
	logic tmr_en;
	logic tmr_ext;
	logic core_run;
	logic [31:0] r;
	logic e;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int d;
	int p1;
	int p2;
	int fac;
	int old;

	always #4 clk = ~clk;

	scps_osc_model #(.HALF_NS(20)) i_osc (.i_slow(slow), .o_wdt_osc(wdt));

	scps_top #(.WDT_LONG_CYCLES(64), .WAKE_LF_SLOW_CYCLES(40)) i_dut (
		.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_clock_source_select_fuses(clock_source_select_fuses), .i_startup_time_fuses(startup_time_fuses),
		.i_clock_output_fuse(clock_output_fuse), .i_initial_divide_by_eight_fuse(div8),
		.i_factory_trim(8'h5A), .i_wdt_osc(wdt), .i_wake_req(wake),
		.i_port_out(port_out), .i_port_oe(port_oe), .o_sys_clk(sys_clk),
		.o_sys_clk_en(sys_en), .o_clock_output_pin(pin),
		.o_clock_output_pin_oe(pin_oe), .o_source(source),
		.o_rc_trim_value(rc_trim), .o_timer_osc_enable(tmr_en),
		.o_timer_external_clock_select(tmr_ext), .o_core_run(core_run));

	task give_verdict;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: run timed out", $time);
			give_verdict();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one bus transfer: setup, then access until ready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the write settle before callers look at outputs
		@(negedge clk);
	endtask : apb

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(r, exp);
	endtask : rd_chk

	task restart(input logic [3:0] cs, input logic [1:0] st,
		input logic co, input logic d8, input int lim);
		@(posedge clk);
		rst <= 1'b1;
		clock_source_select_fuses <= cs;
		startup_time_fuses <= st;
		clock_output_fuse <= co;
		div8 <= d8;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		d = 0;
		while (core_run !== 1'b1 && d < lim) begin
			@(negedge clk);
			d = d + 1;
		end
	endtask : restart

	// pulse a wake request and count cycles with the core held
	task wake_len(input int lim);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		d = 0;
		@(negedge clk);
		while (core_run !== 1'b1 && d < lim) begin
			d = d + 1;
			@(negedge clk);
		end
	endtask : wake_len

	initial begin
		restart(4'h2, 2'h0, 1'b0, 1'b0, 100);
		check(d >= 14 && d <= 18, 1);
		check(source, 2'h2);
		check(rc_trim, 7'h5A);
		rd_chk(scps_pkg::ADDR_TRIM, 32'h5A);
		rd_chk(scps_pkg::ADDR_PRESCALE, 32'h3);
		@(negedge clk);
		check({pin_oe, pin}, {1'b1, sys_clk});
		apb(1'b0, 8'h10, 32'h0);
		check(e, 1'b1);
		check(r, 32'h0);
		apb(1'b1, scps_pkg::ADDR_TRIM, 32'h00);
		check(rc_trim, 7'h00);
		apb(1'b1, scps_pkg::ADDR_TRIM, 32'h7F); // no memory writes
		check(rc_trim, 7'h7F);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h81);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h01);
		rd_chk(scps_pkg::ADDR_PRESCALE, 32'h3);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h80);
		repeat (5) @(posedge clk);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h01);
		rd_chk(scps_pkg::ADDR_PRESCALE, 32'h3);
		apb(1'b0, scps_pkg::ADDR_STATUS, 32'h0);
		check(r & 32'h80, 32'h0);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h80);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h80);
		apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h01);
		rd_chk(scps_pkg::ADDR_PRESCALE, 32'h3);
		old = 8;
		for (int k = 0; k < 10; k++) begin
			fac = (k > 8) ? 256 : (1 << k);
			apb(1'b1, scps_pkg::ADDR_PRESCALE, 32'h80);
			apb(1'b1, scps_pkg::ADDR_PRESCALE, k);
			p1 = 0;
			p2 = 0;
			while (sys_en !== 1'b1 && p1 < 600) begin
				@(negedge clk);
				p1++;
			end
			do begin @(negedge clk); p2++; end while (sys_en !== 1'b1 && p2 < 600);
			check(p1 < old, 1);
			check(p2, fac);
			old = fac;
		end
		apb(1'b1, scps_pkg::ADDR_TIMER, 32'h3);
		check({tmr_en, tmr_ext}, 2'b11);
		wake_len(100);
		check(d, 6);
		@(posedge clk);
		clock_source_select_fuses <= 4'h0;
		repeat (3) @(posedge clk);
		check(source, 2'h2);
		restart(4'h6, 2'h1, 1'b1, 1'b1, 30000);
		check(d >= 4096 * WDT_P && d <= 4096 * WDT_P + 40, 1);
		check(source, 2'h1);
		rd_chk(scps_pkg::ADDR_PRESCALE, 32'h0);
		check({pin_oe, pin}, {port_oe, port_out});
		apb(1'b1, scps_pkg::ADDR_TIMER, 32'h3);
		check({tmr_en, tmr_ext}, 2'b00);
		wake_len(2000);
		check(d, 1024);
		slow <= 1'b1;
		restart(4'h7, 2'h2, 1'b1, 1'b1, 2000);
		check(d >= 64 * 2 * WDT_P && d <= 64 * 2 * WDT_P + 60, 1);
		wake_len(200);
		check(d, 40);
		restart(4'h0, 2'h0, 1'b1, 1'b1, 100);
		check(d >= 14 && d <= 18, 1);
		check(source, 2'h3);
		wake_len(100);
		check(d, 6);
		for (int k = 0; k < 4; k++) begin
			restart((k == 0) ? 4'h3 : (k == 1) ? 4'h1 : (k == 2) ? 4'h5 : 4'h4,
				2'h0, 1'b1, 1'b1, 60);
			check({source, core_run}, 3'b000);
		end
		give_verdict();
	end
endmodule : scps_top_tb
